/* File: core/dacc_pkg.sv */
// Shared constants for the stereo converter clock and output control block.
// Assumes a 250 MHz system clock and an Avalon-MM register master.
// Overview of operation
// - Accept 32 to 768 kHz rates or autodetect.
// - Autodetect needs low rate, master clock, secondary; the code checks for PCM mode instead of a low rate.
// - Source select 0 bypasses, 1 uses PLL.
// - Reference select 1 master, 0 bit clock.
// - Bit clock reference only in secondary mode.
// - Rate code maps 44.1 family frequencies.
// - Rate code maps 48 family frequencies.
// - Rate code ignored while PLL bypassed.
// - Bitstream reference select 1 master, 0 stream.
// - Each channel has its own path enable.
// - Reference power-down forces every path off.
// - First enable waits a settle delay, 1 s.
// - Settle delay skippable and length configurable.
// - Per-channel polarity flip negates output.
// - Gain 0 to -127.5 dB in 0.5 dB steps, mute.
// - Gain and mute staged until commit written.
// - Ramp up with rise rate, down with fall rate.
// - Hardware mode enables all at unity gain.
// - Clock fields latch on global enable rise.
package dacc_pkg;
   // Register byte addresses.
   localparam logic [7:0] ADDR_GLOBAL = 8'h00;
   localparam logic [7:0] ADDR_CLOCK  = 8'h04;
   localparam logic [7:0] ADDR_PATH   = 8'h08;
   localparam logic [7:0] ADDR_DELAY  = 8'h0c;
   localparam logic [7:0] ADDR_GAIN1  = 8'h10;
   localparam logic [7:0] ADDR_GAIN2  = 8'h14;
   localparam logic [7:0] ADDR_COMMIT = 8'h18;
   localparam logic [7:0] ADDR_RAMP   = 8'h1c;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   // Clock register fields.
   localparam int CLK_SRC_BIT  = 0;
   localparam int CLK_REF_BIT  = 1;
   localparam int CLK_CODE_LSB = 2;
   localparam int CLK_RATE_LSB = 4;
   localparam int CLK_SEC_BIT  = 8;
   localparam int CLK_BS_BIT   = 9;
   localparam int CLK_OSR_LSB  = 10;
   // Sample-rate codes.
   localparam logic [3:0] RATE_AUTO  = 4'h0;
   localparam logic [3:0] RATE_32K   = 4'h1;
   localparam logic [3:0] RATE_192K  = 4'h7;
   localparam logic [3:0] RATE_768K  = 4'hb;
   localparam logic [3:0] RATE_44FAM = 4'h2;
   // Reset values.
   localparam logic [11:0] CLOCK_RST = 12'h0f1;
   localparam logic [7:0]  GAIN_RST  = 8'h00;
   localparam logic [7:0]  GAIN_MIN  = 8'hff;
   localparam logic [3:0]  DLEN_RST  = 4'h8;
   localparam logic [3:0]  RISE_RST  = 4'h3;
   localparam logic [3:0]  FALL_RST  = 4'h3;
   // Timing: settle delay of 1 s split into eight length steps of 125 ms.
   localparam longint CLK_HZ       = 250000000;
   localparam longint SETTLE_MS    = 1000;
   localparam longint SETTLE_CYC   = CLK_HZ / 1000 * SETTLE_MS;
   localparam longint DSTEP_CYC    = SETTLE_CYC / 8;
   // Ramp tick: one 0.5 dB step per base period times two to the rate.
   localparam longint RAMP_BASE_NS = 1000;
   localparam longint RAMP_BASE_CYC = RAMP_BASE_NS * CLK_HZ / 1000000000;
endpackage

/* File: core/dacc_ramp.sv */
// One channel gain ramp: steps the applied attenuation toward a target.
// Assumes the rate fields stay still while a ramp runs.
module dacc_ramp
   import dacc_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   // Step timing.
   input  wire logic       base_tick,
   input  wire logic [3:0] rise_rate,
   input  wire logic [3:0] fall_rate,
   // Target, in 0.5 dB attenuation steps.
   input  wire logic [7:0] target,
   // Applied attenuation.
   output logic [7:0]      atten,
   output logic            busy
);
   logic [15:0] div_r;
   logic [15:0] lim;
   logic        up;

   // More attenuation means a gain decrease.
   assign up   = target < atten;
   assign lim  = 16'h1 << (up ? rise_rate : fall_rate);
   assign busy = target != atten;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         div_r <= 16'h0;
      end else if (!busy) begin
         div_r <= 16'h0;
      end else if (base_tick) begin
         div_r <= (div_r + 16'h1 >= lim) ? 16'h0 : div_r + 16'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         atten <= GAIN_RST;
      end else if (busy && base_tick && (div_r + 16'h1 >= lim)) begin
         atten <= up ? atten - 8'h1 : atten + 8'h1;
      end
   end
endmodule

/* File: core/dacc_tick.sv */
// Free-running divider giving a one-cycle enable every PERIOD cycles.
// Assumes a single clock domain.
module dacc_tick #(
   parameter int PERIOD = 250
) (
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic rstn,
   // Enable pulse.
   output logic      tick
);
   logic [31:0] cnt_r;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 32'h0;
         tick  <= 1'b0;
      end else if (cnt_r == 32'(PERIOD - 1)) begin
         cnt_r <= 32'h0;
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 32'h1;
         tick  <= 1'b0;
      end
   end
endmodule

/* File: core/dacc_top.sv */
// Clock configuration and output path control with an Avalon-MM slave.
// Assumes the mode strap arrives asynchronously on a pin.
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
module dacc_top
   import dacc_pkg::*;
#(
   parameter longint SETTLE_STEP = DSTEP_CYC,
   parameter int     RAMP_TICK   = int'(RAMP_BASE_CYC)
) (
   // Clock and reset.
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // Avalon-MM slave.
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Mode strap, high for software control.
   input  wire logic        sw_mode_pin,
   // Active clock configuration.
   output logic             core_clock_source_sel,
   output logic             pll_ref_select,
   output logic [1:0]       pll_ref_rate_code,
   output logic             pll_ref_is_master,
   output logic             pll_ref_is_stream,
   output logic [3:0]       sample_rate,
   output logic [1:0]       bitstream_oversample_ratio,
   output logic             autodetect_on,
   output logic             config_error,
   // Output paths.
   output logic             ref_enable,
   output logic [1:0]       chan_path_enable,
   output logic [1:0]       chan_polarity_flip,
   output logic [7:0]       chan_atten1,
   output logic [7:0]       chan_atten2
);
   logic        sw_s1_r, sw_s2_r;
   logic        global_en_r, global_en_d_r;
   logic [11:0] clock_wr_r, clock_act_r;
   logic        ref_pd_r;
   logic [1:0]  path_en_r, flip_r;
   logic        dly_en_r;
   logic [3:0]  dly_len_r;
   logic [7:0]  gain_stage_r [2];
   logic [1:0]  mute_stage_r;
   logic [7:0]  target_r [2];
   logic [3:0]  rise_r, fall_r;
   logic        settled_r;
   logic [35:0] settle_cnt_r;
   logic        settling;
   logic        want_on;
   logic        base_tick;
   logic [7:0]  atten [2];
   logic [1:0]  busy;
   logic        ack_r;
   logic        wr_go, rd_go;
   logic [31:0] wmask;
   logic        src_pll, ref_mst, bs_mode, sec_mode;
   logic [3:0]  rate;

   // The strap is a pin; two flops before anything reads it.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sw_s1_r <= 1'b0;
         sw_s2_r <= 1'b0;
      end else begin
         sw_s1_r <= sw_mode_pin;
         sw_s2_r <= sw_s1_r;
      end
   end

   // One wait state per access: waitrequest drops for one cycle.
   assign wr_go           = avs_write && !ack_r;
   assign rd_go           = avs_read && !ack_r;
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read || avs_write) && !ack_r;
      end
   end

   // Writes land on the cycle waitrequest is low.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         global_en_r  <= 1'b0;
         clock_wr_r   <= CLOCK_RST;
         ref_pd_r     <= 1'b0;
         path_en_r    <= 2'b00;
         flip_r       <= 2'b00;
         dly_en_r     <= 1'b1;
         dly_len_r    <= DLEN_RST;
         gain_stage_r <= '{GAIN_RST, GAIN_RST};
         mute_stage_r <= 2'b00;
         rise_r       <= RISE_RST;
         fall_r       <= FALL_RST;
      end else if (avs_write && ack_r) begin
         unique case (avs_address)
            ADDR_GLOBAL: if (avs_byteenable[0]) global_en_r <= avs_writedata[0];
            ADDR_CLOCK:  clock_wr_r <= (clock_wr_r & ~wmask[11:0])
                                       | (avs_writedata[11:0] & wmask[11:0]);
            ADDR_PATH: if (avs_byteenable[0]) begin
               path_en_r <= avs_writedata[1:0];
               flip_r    <= avs_writedata[3:2];
               ref_pd_r  <= avs_writedata[4];
            end
            ADDR_DELAY: if (avs_byteenable[0]) begin
               dly_en_r  <= avs_writedata[0];
               dly_len_r <= avs_writedata[7:4];
            end
            ADDR_GAIN1: begin
               if (avs_byteenable[0]) gain_stage_r[0] <= avs_writedata[7:0];
               if (avs_byteenable[1]) mute_stage_r[0] <= avs_writedata[8];
            end
            ADDR_GAIN2: begin
               if (avs_byteenable[0]) gain_stage_r[1] <= avs_writedata[7:0];
               if (avs_byteenable[1]) mute_stage_r[1] <= avs_writedata[8];
            end
            ADDR_RAMP: if (avs_byteenable[0]) begin
               rise_r <= avs_writedata[3:0];
               fall_r <= avs_writedata[7:4];
            end
            default: ;
         endcase
      end
   end

   // Clocking takes effect only on the rising edge of global enable.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         global_en_d_r <= 1'b0;
         clock_act_r   <= CLOCK_RST;
      end else begin
         global_en_d_r <= global_en_r;
         if (global_en_r && !global_en_d_r) begin
            clock_act_r <= clock_wr_r;
         end
      end
   end

   assign src_pll  = clock_act_r[CLK_SRC_BIT];
   assign ref_mst  = clock_act_r[CLK_REF_BIT];
   assign rate     = clock_act_r[CLK_RATE_LSB +: 4];
   assign sec_mode = clock_act_r[CLK_SEC_BIT];
   assign bs_mode  = clock_act_r[CLK_BS_BIT];

   assign core_clock_source_sel      = src_pll;
   // Reference choice and rate code only matter with the PLL in use.
   assign pll_ref_select             = src_pll & ref_mst;
   assign pll_ref_rate_code          = src_pll ? clock_act_r[CLK_CODE_LSB +: 2] : 2'b00;
   assign pll_ref_is_master          = !src_pll || ref_mst;
   assign pll_ref_is_stream          = src_pll && !ref_mst && bs_mode;
   assign sample_rate                = rate;
   assign bitstream_oversample_ratio = clock_act_r[CLK_OSR_LSB +: 2];
   // Autodetect needs the master clock reference and secondary mode.
   assign autodetect_on = !bs_mode && rate == RATE_AUTO && pll_ref_is_master
                          && sec_mode;
   // Flags PCM setups the core cannot run: bad rate codes or unsupported pairings.
   assign config_error = !bs_mode && ((rate > RATE_768K)
                         || (rate == RATE_AUTO && !(pll_ref_is_master && sec_mode))
                         || (src_pll && !ref_mst && !sec_mode));

   // Settle delay: armed after reset or reference power-down.
   assign want_on  = !sw_s2_r || (global_en_r && !ref_pd_r && |path_en_r);
   assign settling = !settled_r && want_on;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         settled_r    <= 1'b0;
         settle_cnt_r <= 36'h0;
      end else if (ref_pd_r && sw_s2_r) begin
         settled_r    <= 1'b0;
         settle_cnt_r <= 36'h0;
      end else if (settling) begin
         if (!dly_en_r || settle_cnt_r >= 36'(SETTLE_STEP) * 36'(dly_len_r)) begin
            settled_r <= 1'b1;
         end else begin
            settle_cnt_r <= settle_cnt_r + 36'h1;
         end
      end
   end

   // Output enables: hardware mode runs both paths at unity gain.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ref_enable       <= 1'b0;
         chan_path_enable <= 2'b00;
      end else if (!sw_s2_r) begin
         ref_enable       <= 1'b1;
         chan_path_enable <= {2{settled_r}};
      end else begin
         ref_enable       <= !ref_pd_r;
         chan_path_enable <= (ref_pd_r || !global_en_r || !settled_r) ? 2'b00 : path_en_r;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         chan_polarity_flip <= 2'b00;
      end else begin
         chan_polarity_flip <= sw_s2_r ? flip_r : 2'b00;
      end
   end

   // Commit applies both staged channels in the same cycle.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         target_r <= '{GAIN_RST, GAIN_RST};
      end else if (!sw_s2_r) begin
         target_r <= '{GAIN_RST, GAIN_RST};
      end else if (avs_write && ack_r && avs_address == ADDR_COMMIT
                   && avs_byteenable[0] && avs_writedata[0]) begin
         for (int i = 0; i < 2; i++) begin
            target_r[i] <= mute_stage_r[i] ? GAIN_MIN : gain_stage_r[i];
         end
      end
   end

   dacc_tick #(
      .PERIOD (RAMP_TICK)
   ) u_tick (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .tick    (base_tick)
   );

   for (genvar c = 0; c < 2; c++) begin : g_ramp
      dacc_ramp u_ramp (
         .clk_sys   (clk_sys),
         .rstn      (rstn),
         .base_tick (base_tick),
         .rise_rate (rise_r),
         .fall_rate (fall_r),
         .target    (target_r[c]),
         .atten     (atten[c]),
         .busy      (busy[c])
      );
   end

   assign chan_atten1 = atten[0];
   assign chan_atten2 = atten[1];

   // Read data registered in the wait cycle, ready when waitrequest drops; unmapped reads give zero.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         avs_readdata <= 32'h0;
      end else if (rd_go) begin
         unique case (avs_address)
            ADDR_GLOBAL: avs_readdata <= {31'h0, global_en_r};
            ADDR_CLOCK:  avs_readdata <= {20'h0, clock_wr_r};
            ADDR_PATH:   avs_readdata <= {27'h0, ref_pd_r, flip_r, path_en_r};
            ADDR_DELAY:  avs_readdata <= {24'h0, dly_len_r, 3'h0, dly_en_r};
            ADDR_GAIN1:  avs_readdata <= {23'h0, mute_stage_r[0], gain_stage_r[0]};
            ADDR_GAIN2:  avs_readdata <= {23'h0, mute_stage_r[1], gain_stage_r[1]};
            ADDR_RAMP:   avs_readdata <= {24'h0, fall_r, rise_r};
            ADDR_STATUS: avs_readdata <= {atten[1], atten[0], 8'h0, autodetect_on,
                                          config_error, busy, chan_path_enable,
                                          sw_s2_r, settled_r};
            default:     avs_readdata <= 32'h0;
         endcase
      end
   end
endmodule

/* File: testbench/dacc_checker.sv */
// Concurrent checks on the clock configuration, path and gain ports.
// Assumes it is bound to dacc_top and sees nothing but its ports.
module dacc_checker
   import dacc_pkg::*;
(
   // Clock and reset.
   input wire logic       clk_sys,
   input wire logic       rstn,
   // Register bus.
   input wire logic [7:0] avs_address,
   input wire logic       avs_write,
   input wire logic       avs_waitrequest,
   // Clock configuration.
   input wire logic       core_clock_source_sel,
   input wire logic       pll_ref_select,
   input wire logic [1:0] pll_ref_rate_code,
   input wire logic       pll_ref_is_master,
   input wire logic       pll_ref_is_stream,
   input wire logic [3:0] sample_rate,
   input wire logic       autodetect_on,
   input wire logic       config_error,
   // Output paths.
   input wire logic       ref_enable,
   input wire logic [1:0] chan_path_enable,
   input wire logic [7:0] chan_atten1,
   input wire logic [7:0] chan_atten2
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   logic glob_wr;
   assign glob_wr = avs_write && !avs_waitrequest && avs_address == ADDR_GLOBAL;
   property p_bypass;
      !core_clock_source_sel |-> pll_ref_rate_code == 2'h0 && !pll_ref_select;
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("reference fields leak through in bypass");
   property p_master;
      core_clock_source_sel && pll_ref_select |-> pll_ref_is_master && !pll_ref_is_stream;
   endproperty
   a_master: assert property (p_master)
      else $error("master reference not chosen");
   property p_stream;
      pll_ref_is_stream |-> core_clock_source_sel && !pll_ref_select && !pll_ref_is_master;
   endproperty
   a_stream: assert property (p_stream)
      else $error("stream reference chosen wrongly");
   property p_auto;
      autodetect_on |-> sample_rate == RATE_AUTO && !(core_clock_source_sel && !pll_ref_select);
   endproperty
   a_auto: assert property (p_auto)
      else $error("autodetect on in an unsupported setup");
   property p_rate;
      sample_rate > RATE_768K |-> config_error;
   endproperty
   a_rate: assert property (p_rate)
      else $error("rate code above range not flagged");
   property p_refdown;
      !ref_enable |-> chan_path_enable == 2'h0;
   endproperty
   a_refdown: assert property (p_refdown)
      else $error("path on with reference off");
   property p_cfg_hold;
      $changed({core_clock_source_sel, pll_ref_select, pll_ref_rate_code, sample_rate})
         |-> $past(glob_wr) || $past(glob_wr, 2);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("clock setup moved without a global enable write");
   property p_step1;
      $changed(chan_atten1) |->
         chan_atten1 - $past(chan_atten1) == 8'h01 || $past(chan_atten1) - chan_atten1 == 8'h01;
   endproperty
   a_step1: assert property (p_step1)
      else $error("channel 1 gain jumped");
   property p_step2;
      $changed(chan_atten2) |->
         chan_atten2 - $past(chan_atten2) == 8'h01 || $past(chan_atten2) - chan_atten2 == 8'h01;
   endproperty
   a_step2: assert property (p_step2)
      else $error("channel 2 gain jumped");
endmodule

bind dacc_top dacc_checker chk_i (.clk_sys, .rstn, .avs_address, .avs_write, .avs_waitrequest,
   .core_clock_source_sel, .pll_ref_select, .pll_ref_rate_code, .pll_ref_is_master,
   .pll_ref_is_stream, .sample_rate, .autodetect_on, .config_error, .ref_enable,
   .chan_path_enable, .chan_atten1, .chan_atten2);

/* File: testbench/dacc_src_model.sv */
// Stand-in for the board side: the control-mode strap.
// Assumes the bench asks for hardware mode through hw_req.
module dacc_src_model (
   // Clock and reset.
   input  wire logic clk_sys,
   input  wire logic rstn,
   // Request from the bench.
   input  wire logic hw_req,
   // Mode strap, high for software control.
   output logic      sw_mode_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // No audio clock reaches this block, so locked and fixed-rate clocks are trivially kept.
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sw_mode_pin <= 1'b1;
      end else begin
         sw_mode_pin <= !hw_req;
      end
   end
endmodule

/* File: testbench/dacc_top_tb.sv */
// Self-checking bench: clock setup latch, path settling, staged gain and ramps.
// Assumes SETTLE_STEP 10 and RAMP_TICK 2; bus waits follow waitrequest.
module dacc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dacc_pkg::*;
   logic        clk_sys, rstn, avs_read, avs_write, avs_waitrequest, hw_req, sw_mode_pin;
   logic        core_clock_source_sel, pll_ref_select, pll_ref_is_master, pll_ref_is_stream;
   logic        autodetect_on, config_error, ref_enable;
   logic [1:0]  pll_ref_rate_code, bitstream_oversample_ratio, chan_path_enable;
   logic [1:0]  chan_polarity_flip;
   logic [3:0]  sample_rate, avs_byteenable;
   logic [7:0]  avs_address, chan_atten1, chan_atten2, t1;
   logic [31:0] avs_writedata, avs_readdata, rd, w, prev;
   int          error_cnt, tests_run, cyc, seed, n;
   logic [11:0] tbl [9] = '{12'h133, 12'h032, 12'h101, 12'h103, 12'h100, 12'h231, 12'h0c3,
                            12'h0b3, 12'h031};
   dacc_top #(.SETTLE_STEP(10), .RAMP_TICK(2)) dut (.clk_sys, .rstn, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .sw_mode_pin, .core_clock_source_sel, .pll_ref_select, .pll_ref_rate_code,
      .pll_ref_is_master, .pll_ref_is_stream, .sample_rate, .bitstream_oversample_ratio,
      .autodetect_on, .config_error, .ref_enable, .chan_path_enable, .chan_polarity_flip,
      .chan_atten1, .chan_atten2);
   dacc_src_model src (.clk_sys, .rstn, .hw_req, .sw_mode_pin);
   // Expected active setup; the reference flags are only defined with the PLL in use.
   // A bad rate, autodetect off the master clock or in primary mode, or a bit clock
   // reference in primary mode is an unusable PCM setup.
   function automatic logic [31:0] exp_cfg(input logic [31:0] c);
      return 32'({c[11:10], c[7:4], c[0], c[0] & c[1], c[0] ? c[3:2] : 2'h0, c[0] & c[1],
                  c[0] & !c[1] & c[9],
                  c[7:4] == 4'h0 && c[8] && !c[9] && (!c[0] || c[1]),
                  !c[9] && (c[7:4] > 4'hb || (c[7:4] == 4'h0 && !(c[8] && (!c[0] || c[1])))
                            || (c[0] && !c[1] && !c[8]))});
   endfunction
   function automatic logic [31:0] cur_cfg();
      return 32'({bitstream_oversample_ratio, sample_rate, core_clock_source_sel,
                  pll_ref_select, pll_ref_rate_code, pll_ref_is_master & core_clock_source_sel,
                  pll_ref_is_stream & core_clock_source_sel, autodetect_on, config_error});
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // Waits for a path mask (k 0) or a channel attenuation (k 1, 2) and counts cycles.
   task automatic wt(input int k, input logic [7:0] v, output int c);
      logic [7:0] cur;
      for (c = 1; c < 5000; c++) begin
         @(posedge clk_sys);
         #1;
         cur = k == 0 ? 8'(chan_path_enable) : k == 1 ? chan_atten1 : chan_atten2;
         if (cur === v) break;
      end
   endtask
   task automatic print_verdict();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = !clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         print_verdict();
      end
   end
   initial begin
      {rstn, avs_read, avs_write, hw_req, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hf;
      seed = 38;
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      bus(1'b0, ADDR_CLOCK, 0);
      chk(rd, 32'(CLOCK_RST));
      bus(1'b0, ADDR_DELAY, 0);
      chk(rd, 32'({DLEN_RST, 4'h1}));
      bus(1'b0, ADDR_RAMP, 0);
      chk(rd, 32'({FALL_RST, RISE_RST}));
      bus(1'b1, 8'h24, 32'($random(seed)));
      bus(1'b0, 8'h24, 0);
      chk(rd, 0);
      prev = exp_cfg(32'(CLOCK_RST));
      chk(cur_cfg(), prev);
      foreach (tbl[i]) begin
         w = 32'(tbl[i]) | (32'($random(seed)) & 32'hc0c);
         bus(1'b1, ADDR_GLOBAL, 0);
         bus(1'b1, ADDR_CLOCK, w);
         repeat (3) @(posedge clk_sys);
         chk(cur_cfg(), prev);
         bus(1'b1, ADDR_GLOBAL, 1);
         repeat (3) @(posedge clk_sys);
         prev = exp_cfg(w);
         chk(cur_cfg(), prev);
      end
      bus(1'b1, ADDR_DELAY, 32'h21);
      bus(1'b1, ADDR_PATH, 32'h0b);
      wt(0, 8'h03, n);
      chk(32'(n >= 20 && n <= 26), 1);
      chk({chan_polarity_flip, chan_path_enable}, 32'hb);
      bus(1'b1, ADDR_PATH, 32'h1b);
      repeat (2) @(posedge clk_sys);
      chk({ref_enable, chan_path_enable}, 0);
      bus(1'b1, ADDR_DELAY, 32'h20);
      bus(1'b1, ADDR_PATH, 32'h01);
      wt(0, 8'h01, n);
      chk(32'(n <= 3), 1);
      bus(1'b1, ADDR_PATH, 32'h03);
      t1 = 8'h08 + (8'($random(seed)) & 8'h1f);
      bus(1'b1, ADDR_RAMP, 0);
      bus(1'b1, ADDR_GAIN1, 32'(t1));
      bus(1'b1, ADDR_GAIN2, 32'h100);
      repeat (20) @(posedge clk_sys);
      chk({chan_atten1, chan_atten2}, 0);
      bus(1'b1, ADDR_COMMIT, 1);
      wt(1, t1, n);
      chk(32'(chan_atten2 != 8'h00 && chan_atten2 != GAIN_MIN), 1);
      wt(2, GAIN_MIN, n);
      chk({chan_atten1, chan_atten2}, {t1, GAIN_MIN});
      // Rates stay fixed while the ramps below run.
      bus(1'b1, ADDR_RAMP, 32'h10);
      bus(1'b1, ADDR_GAIN1, 32'(t1 + 8'h04));
      bus(1'b1, ADDR_COMMIT, 1);
      wt(1, t1 + 8'h04, n);
      chk(32'(n >= 12 && n <= 22), 1);
      bus(1'b1, ADDR_GAIN1, 32'(t1));
      bus(1'b1, ADDR_COMMIT, 1);
      wt(1, t1, n);
      chk(32'(n >= 3 && n <= 11), 1);
      @(posedge clk_sys);
      hw_req <= 1'b1;
      wt(2, 8'h00, n);
      wt(1, 8'h00, n);
      chk({chan_polarity_flip, chan_path_enable, chan_atten1, chan_atten2}, 32'h30000);
      bus(1'b0, ADDR_STATUS, 0);
      chk(32'(rd[1]), 0);
      print_verdict();
   end
endmodule
